/* hw/dee_access.sv */
// data eeprom access unit: 128 byte cells behind index, value, control and unlock registers
//
// How it works
// - 128 byte cells, index 0..7f, reached via index and value registers, read also via programmer port
// - value register is 8 bits: byte to program or byte last read
// - program erases the addressed cell first, then stores the new byte
// - an internal cycle counter times each program operation and signals completion
// - under code protection the cpu still works, programmer port reads zero
// - only index bits 6:0 select the cell, bit 7 ignored
// - control implements four low bits, upper four read zero
// - read and program strobes set-only by software, cleared by hardware at end
// - program only starts while program permit is set
// - program permit is clear after power-up
// - pin or watchdog reset during programming sets fault flag, which survives
// - reset that aborted programming clears index and value registers
// - hardware sets done flag at program end, only a flags read or a reset clears it
// - unlock port stores nothing, reads zero, used only for the unlock sequence
// - control: bit3 fault, bit2 permit, bit1 program strobe, bit0 read strobe
// - brownout ending a program also sets fault; normal completion leaves it zero
//
// The AXI4-Lite interface to the registers was left to the implementer.
`default_nettype none
module dee_access
    import dee_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
    // clock and resets
    input  wire logic         clock_in,
    input  wire logic         reset_in,
    input  wire logic         ext_reset_in,
    input  wire logic         watchdog_expiry_in,
    input  wire logic         brownout_detect_in,
    // register bus
    input  wire dee_axi_req_s axi_req_in,
    output var  dee_axi_rsp_s axi_rsp_out,
    // programmer port
    input  wire logic         code_protect_in,
    input  wire logic         programmer_rd_in,
    input  wire logic [6:0]   programmer_addr_in,
    output logic [7:0]        programmer_data_out,
    // interrupt
    output logic              irq_out
);

    // ==========================================================
    // parameter check
    if (PROG_CYCLES < 2) begin : g_bad_cycles
        $error("PROG_CYCLES must be at least 2");
    end

    localparam logic [31:0] ERASE_CNT = 32'(PROG_CYCLES / 2);
    localparam logic [31:0] WRITE_CNT = 32'(PROG_CYCLES - PROG_CYCLES / 2);

    // ==========================================================
    // state
    typedef struct packed {
        logic [CELLS-1:0][7:0] mem;
        logic [7:0]            value;
        logic [7:0]            index;
        logic                  fault;
        logic                  permit;
        logic                  wr;
        logic                  rd;
        dee_phase_e            phase;
        logic [31:0]           cnt;
        logic [6:0]            pidx;
        logic [7:0]            pdata;
        dee_unlock_e           unlock;
        logic [7:0]            flags;
        logic [7:0]            mask;
        logic                  irq;
        logic                  aw_got;
        logic                  w_got;
        logic [ADDR_W-1:0]     awaddr;
        logic [7:0]            wdata;
        logic                  wen;
        logic [7:0]            prog_data;
        dee_axi_rsp_s          rsp;
    } dee_state_s;

    dee_state_s st_ff;
    dee_state_s nxt_st;

    logic                  abort;
    logic                  busy;
    logic [7:0]            rd_byte;
    logic [7:0]            wbyte;
    logic [ADDR_W-1:0]     waddr;
    logic [ADDR_W-1:0]     raddr;
    logic [7:0]            rbyte;
    logic                  rmapped;
    logic                  wmapped;
    logic [CELLS-1:0][7:0] keep_mem;
    logic                  keep_fault;

    assign busy    = (st_ff.phase != PH_IDLE);
    assign rd_byte = st_ff.mem[st_ff.index[6:0]];

    // ==========================================================
    // next state
    always_comb begin
        nxt_st     = st_ff;
        abort      = ext_reset_in | watchdog_expiry_in | brownout_detect_in;
        waddr      = st_ff.awaddr;
        wbyte      = st_ff.wdata;
        raddr      = axi_req_in.araddr;
        rbyte      = RST_BYTE;
        rmapped    = 1'b0;
        wmapped    = 1'b0;
        keep_mem   = st_ff.mem;
        keep_fault = st_ff.fault;

        // bus read; flag clear comes first so a same-cycle set wins
        if (st_ff.rsp.rvalid && axi_req_in.rready) begin
            nxt_st.rsp.rvalid = 1'b0;
        end
        if (st_ff.rsp.arready && axi_req_in.arvalid) begin
            if (raddr == {2'h0, IDX_VALUE, 2'h0}) begin
                rbyte   = st_ff.value;
                rmapped = 1'b1;
            end else if (raddr == {2'h0, IDX_INDEX, 2'h0}) begin
                rbyte   = st_ff.index;
                rmapped = 1'b1;
            end else if (raddr == {2'h0, IDX_CONTROL, 2'h0}) begin
                rbyte   = {4'h0, st_ff.fault, st_ff.permit,
                           st_ff.wr, st_ff.rd};
                rmapped = 1'b1;
            end else if (raddr == {2'h0, IDX_UNLOCK, 2'h0}) begin
                rbyte   = RST_BYTE;
                rmapped = 1'b1;
            end else if (raddr == {2'h0, IDX_FLAGS, 2'h0}) begin
                rbyte        = st_ff.flags;
                rmapped      = 1'b1;
                nxt_st.flags = 8'h00;
            end else if (raddr == {2'h0, IDX_MASK, 2'h0}) begin
                rbyte   = st_ff.mask;
                rmapped = 1'b1;
            end
            nxt_st.rsp.rdata  = {24'h000000, rbyte};
            nxt_st.rsp.rresp  = rmapped ? RESP_OKAY : RESP_SLVERR;
            nxt_st.rsp.rvalid = 1'b1;
        end

        // bus write: address and data taken in either order
        if (st_ff.rsp.bvalid && axi_req_in.bready) begin
            nxt_st.rsp.bvalid = 1'b0;
        end
        if (st_ff.rsp.awready && axi_req_in.awvalid) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = axi_req_in.awaddr;
        end
        if (st_ff.rsp.wready && axi_req_in.wvalid) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = axi_req_in.wdata[7:0];
            nxt_st.wen   = axi_req_in.wstrb[0];
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.rsp.bvalid) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.unlock = UL_IDLE;
            if (waddr == {2'h0, IDX_VALUE, 2'h0}) begin
                wmapped = 1'b1;
                if (st_ff.wen) nxt_st.value = wbyte;
            end else if (waddr == {2'h0, IDX_INDEX, 2'h0}) begin
                wmapped = 1'b1;
                if (st_ff.wen) nxt_st.index = wbyte;
            end else if (waddr == {2'h0, IDX_CONTROL, 2'h0}) begin
                wmapped = 1'b1;
                if (st_ff.wen) begin
                    nxt_st.fault  = wbyte[CTL_FAULT];
                    nxt_st.permit = wbyte[CTL_PERMIT];
                    // strobes can only be set here, never cleared
                    if (wbyte[CTL_RD]) nxt_st.rd = 1'b1;
                    if (wbyte[CTL_WR] && st_ff.unlock == UL_ARMED
                        && st_ff.permit && !busy) begin
                        nxt_st.wr    = 1'b1;
                        nxt_st.phase = PH_ERASE;
                        nxt_st.cnt   = ERASE_CNT - 32'h1;
                        nxt_st.pidx  = st_ff.index[6:0];
                        nxt_st.pdata = st_ff.value;
                    end
                end
            end else if (waddr == {2'h0, IDX_UNLOCK, 2'h0}) begin
                wmapped = 1'b1;
                if (st_ff.wen && wbyte == KEY_FIRST) begin
                    nxt_st.unlock = UL_HALF;
                end else if (st_ff.wen && wbyte == KEY_SECOND
                             && st_ff.unlock == UL_HALF) begin
                    nxt_st.unlock = UL_ARMED;
                end
            end else if (waddr == {2'h0, IDX_FLAGS, 2'h0}) begin
                wmapped = 1'b1;
            end else if (waddr == {2'h0, IDX_MASK, 2'h0}) begin
                wmapped = 1'b1;
                if (st_ff.wen) nxt_st.mask = wbyte;
            end
            nxt_st.rsp.bvalid = 1'b1;
            nxt_st.rsp.bresp  = wmapped ? RESP_OKAY : RESP_SLVERR;
        end

        // read strobe: cell byte lands one cycle after the strobe is set
        if (st_ff.rd) begin
            nxt_st.value = rd_byte;
            nxt_st.rd    = 1'b0;
        end

        // self-timed erase then write
        case (st_ff.phase)
            PH_ERASE: begin
                if (st_ff.cnt == 32'h0) begin
                    nxt_st.mem[st_ff.pidx] = ERASED_BYTE;
                    nxt_st.phase           = PH_WRITE;
                    nxt_st.cnt             = WRITE_CNT - 32'h1;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 32'h1;
                end
            end
            PH_WRITE: begin
                if (st_ff.cnt == 32'h0) begin
                    nxt_st.mem[st_ff.pidx]  = st_ff.pdata;
                    nxt_st.phase            = PH_IDLE;
                    nxt_st.wr               = 1'b0;
                    nxt_st.flags[FLAG_DONE] = 1'b1;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 32'h1;
                end
            end
            default: begin
            end
        endcase

        // programmer port, shut off under code protection
        if (code_protect_in) begin
            nxt_st.prog_data = RST_BYTE;
        end else if (programmer_rd_in) begin
            nxt_st.prog_data = st_ff.mem[programmer_addr_in];
        end

        // channel readies follow the pending state
        nxt_st.rsp.awready = !nxt_st.aw_got && !nxt_st.rsp.bvalid;
        nxt_st.rsp.wready  = !nxt_st.w_got && !nxt_st.rsp.bvalid;
        nxt_st.rsp.arready = !nxt_st.rsp.rvalid;

        // device resets: cells are nonvolatile, fault flag survives warm resets
        if (reset_in || abort) begin
            nxt_st             = '0;
            nxt_st.mem         = keep_mem;
            nxt_st.rsp.awready = 1'b1;
            nxt_st.rsp.wready  = 1'b1;
            nxt_st.rsp.arready = 1'b1;
            if (!reset_in) begin
                nxt_st.fault = keep_fault | busy;
            end
        end

        nxt_st.irq = |(nxt_st.flags & nxt_st.mask);
    end

    always_ff @(posedge clock_in) begin
        st_ff <= nxt_st;
    end

    assign axi_rsp_out         = st_ff.rsp;
    assign programmer_data_out = st_ff.prog_data;
    assign irq_out             = st_ff.irq;

    // ==========================================================
    // checks
    property p_rd_load;
        @(posedge clock_in) disable iff (reset_in || abort)
        st_ff.rd |=> !st_ff.rd && st_ff.value == $past(rd_byte);
    endproperty
    a_rd_load: assert property (p_rd_load)
        else $error("read strobe did not load cell");

    property p_upper_zero;
        @(posedge clock_in) disable iff (reset_in)
        st_ff.rsp.rvalid |-> st_ff.rsp.rdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read bits not zero");

    property p_permit_gate;
        @(posedge clock_in) disable iff (reset_in)
        $rose(st_ff.wr) |-> $past(st_ff.permit) && $past(st_ff.unlock) == UL_ARMED;
    endproperty
    a_permit_gate: assert property (p_permit_gate)
        else $error("program started unpermitted");

    property p_wr_held;
        @(posedge clock_in) disable iff (reset_in || abort)
        st_ff.wr && !(st_ff.phase == PH_WRITE && st_ff.cnt == 32'h0) && !abort && !reset_in
        |=> st_ff.wr;
    endproperty
    a_wr_held: assert property (p_wr_held)
        else $error("program strobe cleared early");

    property p_abort_fault;
        @(posedge clock_in) disable iff (reset_in)
        abort && busy |=> st_ff.fault && st_ff.index == 8'h00 && st_ff.value == 8'h00;
    endproperty
    a_abort_fault: assert property (p_abort_fault)
        else $error("aborted program not flagged");

    property p_done;
        @(posedge clock_in) disable iff (reset_in || abort)
        st_ff.phase == PH_WRITE && st_ff.cnt == 32'h0
        |=> st_ff.flags[FLAG_DONE] && !st_ff.wr && st_ff.mem[st_ff.pidx] == st_ff.pdata;
    endproperty
    a_done: assert property (p_done)
        else $error("program end not reported");

    property p_erase_first;
        @(posedge clock_in) disable iff (reset_in || abort)
        st_ff.phase == PH_ERASE && st_ff.cnt == 32'h0
        |=> st_ff.phase == PH_WRITE && st_ff.mem[st_ff.pidx] == ERASED_BYTE;
    endproperty
    a_erase_first: assert property (p_erase_first)
        else $error("cell not erased first");

    property p_protect;
        @(posedge clock_in) disable iff (reset_in)
        code_protect_in |=> programmer_data_out == 8'h00;
    endproperty
    a_protect: assert property (p_protect)
        else $error("programmer read under protection");

    property p_irq;
        @(posedge clock_in) disable iff (reset_in)
        ##1 irq_out == |(st_ff.flags & st_ff.mask);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output mismatch");

    property p_unlock_zero;
        @(posedge clock_in) disable iff (reset_in || abort)
        st_ff.rsp.arready && axi_req_in.arvalid
        && axi_req_in.araddr == {2'h0, IDX_UNLOCK, 2'h0} |=> st_ff.rsp.rdata == 32'h0;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero)
        else $error("unlock port read not zero");

    property p_power_clear;
        @(posedge clock_in)
        reset_in |=> !st_ff.permit && !st_ff.fault && !st_ff.wr && !st_ff.rd;
    endproperty
    a_power_clear: assert property (p_power_clear)
        else $error("power reset left permit or strobes set");

    property p_warm_clear;
        @(posedge clock_in) disable iff (reset_in)
        abort |=> st_ff.index == 8'h00 && st_ff.value == 8'h00 && !st_ff.permit;
    endproperty
    a_warm_clear: assert property (p_warm_clear)
        else $error("warm reset kept index or value");

    property p_fault_keep;
        @(posedge clock_in) disable iff (reset_in)
        abort |=> st_ff.fault == ($past(st_ff.fault) || $past(busy));
    endproperty
    a_fault_keep: assert property (p_fault_keep)
        else $error("fault flag wrong after warm reset");

    // cells may only move while a program operation runs
    property p_mem_idle;
        @(posedge clock_in) disable iff (reset_in)
        !busy |=> $stable(st_ff.mem);
    endproperty
    a_mem_idle: assert property (p_mem_idle)
        else $error("cell changed without program");

    property p_done_hw;
        @(posedge clock_in) disable iff (reset_in)
        !st_ff.flags[FLAG_DONE] && !(st_ff.phase == PH_WRITE && st_ff.cnt == 32'h0)
        |=> !st_ff.flags[FLAG_DONE];
    endproperty
    a_done_hw: assert property (p_done_hw)
        else $error("done flag set outside program end");

    property p_prog_hold;
        @(posedge clock_in) disable iff (reset_in || abort)
        !code_protect_in && !programmer_rd_in && !reset_in && !abort
        |=> $stable(programmer_data_out);
    endproperty
    a_prog_hold: assert property (p_prog_hold)
        else $error("programmer data changed without a read");

endmodule : dee_access
`default_nettype wire

/* hw/dee_pkg.sv */
// package: register map, field layout, timing and carrier types of the data eeprom unit
`default_nettype none
package dee_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0]  IDX_VALUE    = 8'h9a;
    localparam logic [7:0]  IDX_INDEX    = 8'h9b;
    localparam logic [7:0]  IDX_CONTROL  = 8'h9c;
    localparam logic [7:0]  IDX_UNLOCK   = 8'h9d;
    localparam logic [7:0]  IDX_FLAGS    = 8'ha0;
    localparam logic [7:0]  IDX_MASK     = 8'ha1;
    localparam int          ADDR_W       = 12;

    // ==========================================================
    // control and flags register fields
    localparam int          CTL_RD       = 0;
    localparam int          CTL_WR       = 1;
    localparam int          CTL_PERMIT   = 2;
    localparam int          CTL_FAULT    = 3;
    localparam int          FLAG_DONE    = 0;

    // ==========================================================
    // unlock key bytes and fixed values
    localparam logic [7:0]  KEY_FIRST    = 8'h55;
    localparam logic [7:0]  KEY_SECOND   = 8'haa;
    localparam logic [7:0]  ERASED_BYTE  = 8'hff;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam int          CELLS        = 128;

    // ==========================================================
    // timing: self-timed program operation
    localparam int          CLK_PERIOD_NS = 8;
    localparam int          PROG_TIME_US  = 5;
    localparam int          PROG_CYCLES_DFLT = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;

    // ==========================================================
    // types
    typedef enum logic [1:0] {PH_IDLE, PH_ERASE, PH_WRITE} dee_phase_e;
    typedef enum logic [1:0] {UL_IDLE, UL_HALF, UL_ARMED} dee_unlock_e;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } dee_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dee_axi_rsp_s;

endpackage : dee_pkg
`default_nettype wire

/* tb/test_data_eeprom_access.sv */
// testbench of the data eeprom access unit: bus tasks, result queues and scenarios
`default_nettype none
module test_data_eeprom_access
    import dee_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // short program time keeps the run brief; waits below are derived from it
    localparam int PROG = 8;

    // ==========================================================
    // signals
    logic         clock_in     = 1'b0;
    logic         reset_in     = 1'b1;
    logic [2:0]   warm         = 3'b000;
    logic         code_protect = 1'b0;
    logic         prog_rd      = 1'b0;
    logic [6:0]   prog_addr    = 7'h00;
    dee_axi_req_s req          = '0;
    dee_axi_rsp_s rsp;
    logic [7:0]   prog_data;
    logic         irq;
    int           fails        = 0;
    int           tests_run    = 0;
    logic [33:0]  exp_r[$];
    logic [1:0]   exp_b[$];
    logic [7:0]   b0;
    logic [7:0]   b1;
    logic [7:0]   regs[6]      = '{IDX_VALUE, IDX_INDEX, IDX_CONTROL, IDX_UNLOCK, IDX_FLAGS,
                                   IDX_MASK};

    dee_access #(.PROG_CYCLES(PROG)) dut_u (
        .clock_in(clock_in), .reset_in(reset_in), .ext_reset_in(warm[0]),
        .watchdog_expiry_in(warm[1]), .brownout_detect_in(warm[2]),
        .axi_req_in(req), .axi_rsp_out(rsp), .code_protect_in(code_protect),
        .programmer_rd_in(prog_rd), .programmer_addr_in(prog_addr),
        .programmer_data_out(prog_data), .irq_out(irq));

    initial begin
        forever #4 clock_in = ~clock_in;
    end

    // ==========================================================
    // checking
    task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // results are compared in the cycle of their handshake, oldest note first
    always @(posedge clock_in) begin
        if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
            if (exp_r.size() == 0)
                check("read without note", '1, '0);
            else
                check("read response", {rsp.rresp, rsp.rdata}, exp_r.pop_front());
        end
        if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
            if (exp_b.size() == 0)
                check("write without note", '1, '0);
            else
                check("write response", 34'(rsp.bresp), 34'(exp_b.pop_front()));
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // bus tasks: handshakes are judged at the falling edge, acted on after the rising one
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] resp = RESP_OKAY, input logic [3:0] strb = 4'hf);
        int   n;
        logic aw_hs;
        logic w_hs;
        logic b_hs;
        exp_b.push_back(resp);
        @(posedge clock_in);
        req.awaddr  <= ADDR_W'({idx, 2'b00});
        req.wdata   <= {24'h000000, d};
        req.wstrb   <= strb;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge clock_in);
            aw_hs = req.awvalid && rsp.awready === 1'b1;
            w_hs  = req.wvalid && rsp.wready === 1'b1;
            b_hs  = rsp.bvalid === 1'b1;
            @(posedge clock_in);
            if (aw_hs)
                req.awvalid <= 1'b0;
            if (w_hs)
                req.wvalid <= 1'b0;
            if (b_hs)
                break;
        end
        req.bready <= 1'b0;
        if (n == 100)
            fails++;
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] resp = RESP_OKAY);
        int   n;
        logic ar_hs;
        logic r_hs;
        exp_r.push_back({resp, 24'h000000, d});
        @(posedge clock_in);
        req.araddr  <= ADDR_W'({idx, 2'b00});
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge clock_in);
            ar_hs = req.arvalid && rsp.arready === 1'b1;
            r_hs  = rsp.rvalid === 1'b1;
            @(posedge clock_in);
            if (ar_hs)
                req.arvalid <= 1'b0;
            if (r_hs)
                break;
        end
        req.rready <= 1'b0;
        if (n == 100)
            fails++;
    endtask : rd

    task automatic cycles(input int n);
        repeat (n) @(posedge clock_in);
    endtask : cycles

    // permit bits in ctl; the strobe write follows the two keys directly
    task automatic prog(input logic [7:0] idx, input logic [7:0] d, input logic [7:0] ctl);
        wr(IDX_INDEX, idx);
        wr(IDX_VALUE, d);
        wr(IDX_CONTROL, ctl);
        wr(IDX_UNLOCK, KEY_FIRST);
        wr(IDX_UNLOCK, KEY_SECOND);
        wr(IDX_CONTROL, ctl | 8'h02);
    endtask : prog

    task automatic rdcell(input logic [7:0] idx, input logic [7:0] exp);
        wr(IDX_INDEX, idx);
        wr(IDX_CONTROL, 8'h01);
        rd(IDX_VALUE, exp);
        rd(IDX_CONTROL, 8'h00);
    endtask : rdcell

    // k 0..2 are the warm resets, 3 the power reset
    task automatic pulse(input int k);
        @(posedge clock_in);
        if (k == 3)
            reset_in <= 1'b1;
        else
            warm[k] <= 1'b1;
        @(posedge clock_in);
        reset_in <= 1'b0;
        warm     <= 3'b000;
    endtask : pulse

    // ==========================================================
    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clock_in);
        fails++;
        end_of_test();
    end

    // ==========================================================
    // scenarios
    initial begin
        void'($urandom(32'h41dd6a50));
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        repeat (5) @(posedge clock_in);
        reset_in <= 1'b0;
        foreach (regs[i]) rd(regs[i], 8'h00);
        rd(8'h90, 8'h00, RESP_SLVERR);
        wr(8'h90, 8'h5a, RESP_SLVERR);
        // masked completion: flag set, no interrupt, flag cleared by reading
        prog(8'h05, b0, 8'h04);
        rd(IDX_CONTROL, 8'h06);
        cycles(PROG + 4);
        rd(IDX_CONTROL, 8'h04);
        @(negedge clock_in);
        check("irq masked", 34'(irq), 34'h0);
        rd(IDX_FLAGS, 8'h01);
        rd(IDX_FLAGS, 8'h00);
        rdcell(8'h85, b0);
        // programmer port sees the cell only while unprotected
        @(posedge clock_in);
        prog_rd   <= 1'b1;
        prog_addr <= 7'h05;
        cycles(2);
        @(negedge clock_in);
        check("programmer data", 34'(prog_data), 34'(b0));
        @(posedge clock_in);
        code_protect <= 1'b1;
        cycles(2);
        @(negedge clock_in);
        check("programmer blocked", 34'(prog_data), 34'h0);
        // unmasked completion at the top cell
        wr(IDX_MASK, 8'h01);
        // byte lane 0 off: the write is answered but leaves the mask alone
        wr(IDX_MASK, 8'h00, RESP_OKAY, 4'he);
        rd(IDX_MASK, 8'h01);
        prog(8'h7f, b1, 8'h04);
        cycles(PROG + 4);
        @(negedge clock_in);
        check("irq raised", 34'(irq), 34'h1);
        rd(IDX_FLAGS, 8'h01);
        cycles(2);
        @(negedge clock_in);
        check("irq cleared", 34'(irq), 34'h0);
        rdcell(8'h7f, b1);
        // no permit: strobe ignored, cell kept
        prog(8'h05, ~b0, 8'h00);
        cycles(PROG + 4);
        rd(IDX_CONTROL, 8'h00);
        rd(IDX_FLAGS, 8'h00);
        rdcell(8'h05, b0);
        // key sequence broken by another write: no program
        wr(IDX_INDEX, 8'h05);
        wr(IDX_CONTROL, 8'h04);
        wr(IDX_UNLOCK, KEY_FIRST);
        wr(IDX_VALUE, ~b0);
        wr(IDX_UNLOCK, KEY_SECOND);
        wr(IDX_CONTROL, 8'h06);
        cycles(PROG + 4);
        rd(IDX_FLAGS, 8'h00);
        rdcell(8'h05, b0);
        wr(IDX_UNLOCK, 8'h12);
        rd(IDX_UNLOCK, 8'h00);
        wr(IDX_CONTROL, 8'hf0);
        rd(IDX_CONTROL, 8'h00);
        // resets in mid-program: warm ones leave the fault flag, power clears it
        for (int k = 0; k < 4; k++) begin
            prog(8'h03, 8'($urandom), 8'h04);
            cycles(2);
            pulse(k);
            rd(IDX_CONTROL, (k == 3) ? 8'h00 : 8'h08);
            rd(IDX_INDEX, 8'h00);
            rd(IDX_VALUE, 8'h00);
            wr(IDX_CONTROL, 8'h00);
            rd(IDX_CONTROL, 8'h00);
        end
        end_of_test();
    end

endmodule : test_data_eeprom_access
`default_nettype wire
